/* File: bench/host_port_model.sv */
// host side of the byte register port: one strobe per access
// assumes the caller works on the falling edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
    // clock
    input  wire logic       sys_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // idle lines from time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // data is flipped after the strobe so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    // read data is settled half a cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        d        = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: bench/mode3_cfg_reset_reason_regs_tb.sv */
// self-checking bench: register traffic, events, button filter, watchdog
// assumes the host model owns the register port; 1 ms shortened to 2 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module mode3_cfg_reset_reason_regs_tb;
    import reset_regs_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [4:0]  ev = 5'h00;
    logic        mode3_active = 1'b1;
    logic        wd_kick = 1'b0;
    logic        power_button = 1'b1;
    wire  [7:0]  reg_addr;
    wire         reg_wr;
    wire  [7:0]  reg_wdata;
    wire         reg_rd;
    logic [7:0]  reg_rdata;
    logic        reg_hit;
    logic        wd_expire;
    logic [11:0] target_mv;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          n_exp = 0;
    int          evn[3] = '{0, 3, 4};
    int          bitn[3] = '{4, 2, 0};
    host_port_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    mode3_cfg_reset_reason_regs #(.TICK_CYC(2), .FILTER_MS(5)) dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .thermal_exit(ev[0]), .storage_entry(ev[1]), .storage_exit(ev[2]),
        .soft_reset_done(ev[3]), .long_press_done(ev[4]), .mode3_active(mode3_active), .wd_kick(wd_kick),
        .wd_expire(wd_expire), .power_button(power_button), .secondary_linear_regulator_mode3_target_mv(target_mv));
    // free-running 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    // codes past 0x18 clamp at 2100 mV, offset adds 1200 mV
    function automatic logic [11:0] exp_mv(input logic [7:0] d);
        logic [11:0] v;
        v = (d[4:0] > 5'h18) ? 12'h834 : 12'h5DC + 12'h019 * 12'(d[4:0]);
        return d[5] ? v + 12'h4B0 : v;
    endfunction
    // one-cycle event pulse
    task automatic pulse(input int k);
        @(negedge sys_clk);
        ev[k] = 1'b1;
        @(negedge sys_clk);
        ev[k] = 1'b0;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // cycle count, expiry count and hang cut-off
    always @(posedge sys_clk)
    begin
        cyc++;
        if (wd_expire)
            n_exp++;
        if (cyc == 50000)
        begin
            num_errors++;
            end_sim;
        end
    end
    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] v;
        int         n;
        void'($urandom(32'h0F1C));
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        host.rd(8'h31, v);
        `CHK("cfg reset", 8'h0C, v)
        host.rd(8'h71, v);
        `CHK("reason reset", 8'h80, v)
        // clamp corners first, then random bytes
        for (int i = 0; i < 16; i++)
        begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h19 : (i == 2) ? 8'h18 : 8'($urandom);
            host.wr(8'h31, d);
            host.rd(8'h31, v);
            `CHK("cfg rw", d, v)
            `CHK("target", exp_mv(d), target_mv)
        end
        // a write while the enable is low must leave the register alone
        ce = 1'b0;
        host.wr(8'h31, ~d);
        ce = 1'b1;
        host.rd(8'h31, v);
        `CHK("ce freeze", d, v)
        host.wr(8'h55, 8'hA5);
        host.rd(8'h55, v);
        `CHK("unmapped", 8'h00, v)
        `CHK("hit unmapped", 1'b0, reg_hit)
        host.wr(8'h71, 8'h60);
        host.rd(8'h71, v);
        `CHK("reserved", 8'h80, v)
        `CHK("hit reason", 1'b1, reg_hit)
        // thermal, soft reset, long press: set, restore, keep on 0, clear on 1
        for (int k = 0; k < 3; k++)
        begin
            host.wr(8'h31, 8'h95);
            pulse(evn[k]);
            host.wr(8'h71, 8'h00);
            host.rd(8'h71, v);
            `CHK("flag set", 8'h80 | (8'h01 << bitn[k]), v)
            host.rd(8'h31, v);
            `CHK("restore", 8'h0C, v)
            host.wr(8'h71, 8'h01 << bitn[k]);
            host.rd(8'h71, v);
            `CHK("flag clear", 8'h80, v)
        end
        // storage exit, then thermal, then storage entry keeps only bit 3
        pulse(2);
        pulse(0);
        pulse(1);
        host.rd(8'h71, v);
        `CHK("storage", 8'h88, v)
        host.wr(8'h71, 8'h08);
        host.rd(8'h71, v);
        `CHK("storage clear", 8'h80, v)
        // low level must be held before it shows, high shows at once
        power_button = 1'b0;
        repeat (3) @(negedge sys_clk);
        host.rd(8'h71, v);
        `CHK("button early", 1'b1, v[7])
        repeat (20) @(negedge sys_clk);
        host.rd(8'h71, v);
        `CHK("button low", 1'b0, v[7])
        power_button = 1'b1;
        host.rd(8'h71, v);
        `CHK("button high", 1'b1, v[7])
        `CHK("no expiry", 0, n_exp)
        // 16 s period is 16000 ticks of 2 cycles after the return to mode 3
        host.wr(8'h31, 8'h4C);
        pulse(0);
        host.wr(8'h31, 8'h4C);
        host.rd(8'h71, v);
        `CHK("thermal again", 8'h90, v)
        wd_kick = 1'b1;
        @(negedge sys_clk);
        wd_kick = 1'b0;
        // out of mode 3 the count stays at zero, so the period runs from the return
        mode3_active = 1'b0;
        repeat (100) @(negedge sys_clk);
        mode3_active = 1'b1;
        n = 0;
        while (!wd_expire && n < 40000)
        begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("wd period", 1'b1, n > 31990 && n < 32010)
        host.rd(8'h71, v);
        `CHK("wd flag", 8'h92, v)
        host.rd(8'h31, v);
        `CHK("wd keeps cfg", 8'h4C, v)
        end_sim;
    end
endmodule
`default_nettype wire

/* File: bench/regs_monitor.sv */
// assertion checker for the mode 3 config and reset-reason registers
// sees only top-level ports; bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module regs_monitor
(
    // clock and control
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        ce,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    // events, watchdog, button, target
    input wire logic        thermal_exit,
    input wire logic        storage_entry,
    input wire logic        storage_exit,
    input wire logic        soft_reset_done,
    input wire logic        long_press_done,
    input wire logic        mode3_active,
    input wire logic        wd_expire,
    input wire logic        power_button,
    input wire logic [11:0] secondary_linear_regulator_mode3_target_mv
);
    logic       rd_taken_q;
    logic [7:0] wd_q;
    logic [7:0] wd_qq;
    logic       restore;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // delayed copies; plain delays need no reset
    always_ff @(posedge sys_clk)
    begin
        rd_taken_q <= ce && reg_rd;
        wd_q       <= reg_wdata;
        wd_qq      <= wd_q;
    end
    // any event that puts the config register back to defaults
    assign restore = thermal_exit | storage_entry | storage_exit | soft_reset_done | long_press_done;
    a_unmapped_read_zero: assert property (ce && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_read_zero: assert property (ce && reg_rd && reg_addr == 8'h71 |=> reg_rdata[6:5] == 2'h0)
        else $error("reserved bits not zero");
    a_target_decode: assert property (ce && reg_wr && reg_addr == 8'h31 && !restore ##1 ce && !restore
        && !(reg_wr && reg_addr == 8'h31) |=> secondary_linear_regulator_mode3_target_mv == (wd_qq[5] ? 12'h4B0 : 12'h000)
        + (wd_qq[4:0] > 5'h18 ? 12'h834 : 12'h5DC + 12'h019 * 12'(wd_qq[4:0])))
        else $error("regulator target wrong");
    a_restore_target: assert property (ce && restore ##1 ce |=> secondary_linear_regulator_mode3_target_mv == 12'h708)
        else $error("restore did not default target");
    a_wd_mode3_only: assert property (wd_expire |-> $past(mode3_active))
        else $error("expiry outside mode 3");
    a_button_high_fast: assert property (ce && power_button ##1 ce && reg_rd && reg_addr == 8'h71
        |=> reg_rdata[7])
        else $error("button high not shown");
    a_rdata_hold: assert property (!rd_taken_q |-> $stable(reg_rdata))
        else $error("read data moved without read");
    a_soft_flag_clear: assert property (ce && reg_wr && reg_addr == 8'h71 && reg_wdata[2] && !soft_reset_done
        ##1 !soft_reset_done ##1 ce && reg_rd && reg_addr == 8'h71 |=> !reg_rdata[2])
        else $error("soft flag not cleared");
endmodule
bind mode3_cfg_reset_reason_regs regs_monitor u_mon (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .reg_hit, .thermal_exit, .storage_entry, .storage_exit, .soft_reset_done,
    .long_press_done, .mode3_active, .wd_expire, .power_button, .secondary_linear_regulator_mode3_target_mv);
`default_nettype wire

/* File: inc/button_filter_if.sv */
// carries the millisecond tick and power-button levels between the
// register bank and its button debouncer; one clock domain
`timescale 1ns/1ps
`default_nettype none
interface button_filter_if;
    logic tick_ms;     // one-cycle pulse every millisecond
    logic raw_level;   // button pin as sampled
    logic filtered;    // debounced level

    modport bank (output tick_ms, output raw_level, input filtered);
    modport filter (input tick_ms, input raw_level, output filtered);
endinterface
`default_nettype wire

/* File: inc/reset_regs_pkg.sv */
// constants for the mode 3 configuration and reset-reason register pair
// assumes a 250 MHz core clock and a byte-wide register access port
package reset_regs_pkg;

    // register offsets on the byte register port
    localparam logic [7:0] MODE3_CFG_OFFSET    = 8'h31;
    localparam logic [7:0] RESET_REASON_OFFSET = 8'h71;

    // mode3_config_part3 field layout and reset value
    localparam int         WD_FIELD_LSB        = 6;
    localparam int         OFFSET_SEL_BIT      = 5;
    localparam int         VCODE_LSB           = 0;
    localparam logic [1:0] WD_FIELD_RESET      = 2'h0;
    localparam logic       OFFSET_SEL_RESET    = 1'b0;
    localparam logic [4:0] VCODE_RESET         = 5'h0C;

    // reset_reason_monitor field layout
    localparam int         BUTTON_BIT          = 7;
    localparam int         THERMAL_BIT         = 4;
    localparam int         STORAGE_BIT         = 3;
    localparam int         SOFT_BIT            = 2;
    localparam int         WATCHDOG_BIT        = 1;
    localparam int         LONG_PRESS_BIT      = 0;
    localparam logic [4:0] FLAGS_RESET         = 5'h00;
    localparam logic       BUTTON_RESET        = 1'b1;

    // watchdog field codes
    localparam logic [1:0] WD_OFF              = 2'h0;
    localparam logic [1:0] WD_16S              = 2'h1;
    localparam logic [1:0] WD_32S              = 2'h2;
    localparam logic [1:0] WD_64S              = 2'h3;

    // regulator code mapping, millivolts
    localparam logic [4:0]  VCODE_MAX          = 5'h18;
    localparam logic [11:0] VBASE_MV           = 12'h5DC;   // 1500 mV
    localparam logic [11:0] VSTEP_MV           = 12'h019;   // 25 mV
    localparam logic [11:0] VOFFSET_MV         = 12'h4B0;   // 1200 mV

    // timing: times in their own unit, cycle counts derived
    localparam longint CLK_HZ                  = 250_000_000;
    localparam longint MS_PER_S                = 1000;
    localparam longint TICK_CYCLES             = CLK_HZ / MS_PER_S;  // cycles per 1 ms
    localparam int     DEBOUNCE_MS             = 5;
    localparam int     WD_16S_S                = 16;
    localparam int     WD_32S_S                = 32;
    localparam int     WD_64S_S                = 64;
    localparam int     WD_MS_W                 = 17;                 // holds 64000 ms
    localparam int     DEB_CNT_W               = 4;

endpackage

/* File: logic/button_debouncer.sv */
// low-level debouncer for the power-button pin
// assumes the pin is already synchronous to sys_clk and tick_ms pulses once per ms
`timescale 1ns/1ps
`default_nettype none
module button_debouncer
    import reset_regs_pkg::*;
#(
    parameter int FILTER_MS = reset_regs_pkg::DEBOUNCE_MS
)
(
    // clock, reset, enable
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            ce,
    // link to the register bank
    button_filter_if.filter      bf
);
    import reset_regs_pkg::*;

    generate
        if (FILTER_MS < 1 || FILTER_MS >= (1 << DEB_CNT_W))
        begin : g_bad
            $error("button_debouncer: FILTER_MS out of range");
        end
    endgenerate

    logic [DEB_CNT_W-1:0] low_ms_q;
    logic [DEB_CNT_W-1:0] low_ms_d;
    logic                 level_q;
    logic                 level_d;
    logic                 low_done;

    // a whole low stretch must span FILTER_MS ticks; a tick already part-way
    // gone makes the first count short by up to one ms, accepted as jitter
    assign low_done = (low_ms_q == DEB_CNT_W'(FILTER_MS - 1)) && bf.tick_ms;
    assign low_ms_d = bf.raw_level ? '0 : (bf.tick_ms && !low_done) ? low_ms_q + 1'b1 : low_ms_q;
    assign level_d  = bf.raw_level ? 1'b1 : (low_done ? 1'b0 : level_q);

    // filter state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            low_ms_q <= '0;
            level_q  <= BUTTON_RESET;
        end
        else if (ce)
        begin
            low_ms_q <= low_ms_d;
            level_q  <= level_d;
        end
    end

    assign bf.filtered = level_q;
endmodule
`default_nettype wire

/* File: logic/mode3_cfg_reset_reason_regs.sv */
// mode 3 configuration register and reset-reason register with their
// watchdog timer, regulator target decode and power-button filter
// assumes a byte register port fed by the device's I2C target logic, and
// event pulses from the power sequencer, all synchronous to sys_clk
//
// What this block does
// - watchdog field: 00 off, 01 16 s, 10 32 s, 11 64 s in mode 3.
// - offset select adds 0 V or 1.2 V to the coded regulator voltage.
// - voltage code: 1.500 V plus 25 mV per step, codes above 11000 give 2.1 V.
// - config resets to watchdog 00, offset 0, voltage code 01100; all fields read-write.
// - button bit: low shown after 5 ms stable, high at once, read only, resets 1.
// - thermal exit sets bit 4, registers default, cleared by writing 1.
// - storage exit sets bit 3, kept in always-on logic, cleared by writing 1.
// - storage entry or exit clears every reset-reason bit except bit 3.
// - software reset sets bit 2, registers default, cleared by writing 1.
// - watchdog reset sets bit 1, registers kept, cleared by writing 1.
// - long-press reset sets bit 0, registers default, cleared by writing 1.
// - the host reads the reset-reason register at offset 0x71.
`timescale 1ns/1ps
`default_nettype none
module mode3_cfg_reset_reason_regs
    import reset_regs_pkg::*;
#(
    parameter longint TICK_CYC = reset_regs_pkg::TICK_CYCLES,
    parameter int     FILTER_MS = reset_regs_pkg::DEBOUNCE_MS
)
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // byte register port from the I2C target
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_hit,
    // power-sequencer events, one-cycle pulses
    input  wire logic        thermal_exit,
    input  wire logic        storage_entry,
    input  wire logic        storage_exit,
    input  wire logic        soft_reset_done,
    input  wire logic        long_press_done,
    // watchdog
    input  wire logic        mode3_active,
    input  wire logic        wd_kick,
    output logic             wd_expire,
    // power button and regulator target
    input  wire logic        power_button,
    output logic      [11:0] secondary_linear_regulator_mode3_target_mv
);
    import reset_regs_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYC + 1);

    generate
        if (TICK_CYC < 2 || TICK_W > 32)
        begin : g_bad_tick
            $error("mode3_cfg_reset_reason_regs: TICK_CYC out of range");
        end
    endgenerate

    // watchdog period in ms for a field code; zero means disabled
    function automatic logic [WD_MS_W-1:0] wd_limit_ms(input logic [1:0] code);
        logic [WD_MS_W-1:0] lim;
        lim = '0;
        case (code)
            WD_16S:  lim = WD_MS_W'(WD_16S_S * MS_PER_S);
            WD_32S:  lim = WD_MS_W'(WD_32S_S * MS_PER_S);
            WD_64S:  lim = WD_MS_W'(WD_64S_S * MS_PER_S);
            default: lim = '0;
        endcase
        return lim;
    endfunction

    // regulator target in mV from code and offset select
    function automatic logic [11:0] secondary_linear_regulator_mv(input logic [4:0] code, input logic offs);
        logic [4:0]  clamped;
        logic [11:0] mv;
        clamped = (code > VCODE_MAX) ? VCODE_MAX : code;
        mv      = VBASE_MV + 12'(VSTEP_MV * 12'(clamped));
        return offs ? 12'(mv + VOFFSET_MV) : mv;
    endfunction

    // configuration and flag state
    logic [1:0]        wd_field_q;
    logic [1:0]        wd_field_d;
    logic              offset_sel_q;
    logic              offset_sel_d;
    logic [4:0]        vcode_q;
    logic [4:0]        vcode_d;
    logic [4:0]        flags_q;
    logic [4:0]        flags_d;
    logic              storage_flag_q;
    logic              storage_flag_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic [WD_MS_W-1:0] wd_ms_q;
    logic [WD_MS_W-1:0] wd_ms_d;
    logic [11:0]       target_q;
    logic [7:0]        rdata_q;
    logic [7:0]        rdata_d;
    logic              expire_q;

    // address decode
    logic sel_cfg;
    logic sel_rr;
    logic wr_cfg;
    logic wr_rr;
    assign sel_cfg = (reg_addr == MODE3_CFG_OFFSET);
    assign sel_rr  = (reg_addr == RESET_REASON_OFFSET);
    assign wr_cfg  = reg_wr && sel_cfg;
    assign wr_rr   = reg_wr && sel_rr;
    assign reg_hit = sel_cfg || sel_rr;

    // events that restore the registers; a watchdog reset does not
    logic power_cycle;
    logic restore;
    assign power_cycle = storage_entry || storage_exit;
    assign restore     = thermal_exit || power_cycle || soft_reset_done || long_press_done;

    // configuration next state: a restore outranks a same-cycle write
    assign wd_field_d   = restore ? WD_FIELD_RESET :
                          wr_cfg  ? reg_wdata[WD_FIELD_LSB +: 2] : wd_field_q;
    assign offset_sel_d = restore ? OFFSET_SEL_RESET :
                          wr_cfg  ? reg_wdata[OFFSET_SEL_BIT] : offset_sel_q;
    assign vcode_d      = restore ? VCODE_RESET :
                          wr_cfg  ? reg_wdata[VCODE_LSB +: 5] : vcode_q;

    // millisecond prescaler shared by watchdog and button filter
    logic tick_ms;
    assign tick_ms    = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
    assign tick_cnt_d = tick_ms ? '0 : tick_cnt_q + 1'b1;

    // watchdog: runs only in mode 3 with a nonzero period; kick, expiry or any
    // restore starts the count over; a restore also sets the field to off
    logic [WD_MS_W-1:0] wd_limit;
    logic               wd_run;
    logic               wd_hit;
    assign wd_limit = wd_limit_ms(wd_field_q);
    assign wd_run   = mode3_active && (wd_field_q != WD_OFF);
    assign wd_hit   = wd_run && tick_ms && (wd_ms_q == wd_limit - 1'b1);
    assign wd_ms_d  = (!wd_run || wd_kick || restore || wd_hit) ? '0 :
                      tick_ms ? wd_ms_q + 1'b1 : wd_ms_q;

    // reset-reason flags: write 1 clears, a same-cycle event still sets
    logic [4:0] flag_set;
    logic [4:0] flag_w1c;
    logic [4:0] flag_kept;
    assign flag_set[THERMAL_BIT]    = thermal_exit;
    assign flag_set[STORAGE_BIT]    = 1'b0;
    assign flag_set[SOFT_BIT]       = soft_reset_done;
    assign flag_set[WATCHDOG_BIT]   = wd_hit;
    assign flag_set[LONG_PRESS_BIT] = long_press_done;
    assign flag_w1c  = wr_rr ? reg_wdata[4:0] : 5'h00;
    assign flag_kept = power_cycle ? FLAGS_RESET : (flags_q & ~flag_w1c);
    assign flags_d   = flag_kept | flag_set;

    // storage flag lives apart so a core power cycle cannot touch it
    assign storage_flag_d = storage_exit ? 1'b1 :
                            (wr_rr && reg_wdata[STORAGE_BIT]) ? 1'b0 : storage_flag_q;

    // button filter
    button_filter_if bf ();
    assign bf.tick_ms   = tick_ms;
    assign bf.raw_level = power_button;

    button_debouncer #(
        .FILTER_MS (FILTER_MS)
    ) u_button (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .bf      (bf.filter)
    );

    // read view; reserved bits 6:5 are fixed at zero
    logic [7:0] cfg_view;
    logic [7:0] rr_view;
    assign cfg_view = {wd_field_q, offset_sel_q, vcode_q};
    assign rr_view  = {bf.filtered, 2'b00, flags_q[THERMAL_BIT], storage_flag_q,
                       flags_q[SOFT_BIT], flags_q[WATCHDOG_BIT], flags_q[LONG_PRESS_BIT]};
    assign rdata_d  = !reg_rd ? rdata_q :
                      sel_cfg ? cfg_view :
                      sel_rr  ? rr_view : 8'h00;

    // core register state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wd_field_q   <= WD_FIELD_RESET;
            offset_sel_q <= OFFSET_SEL_RESET;
            vcode_q      <= VCODE_RESET;
            flags_q      <= FLAGS_RESET;
        end
        else if (ce)
        begin
            wd_field_q   <= wd_field_d;
            offset_sel_q <= offset_sel_d;
            vcode_q      <= vcode_d;
            flags_q      <= flags_d;
        end
    end

    // always-on storage flag; cleared by the power-on reset or by writing 1 to bit 3
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            storage_flag_q <= 1'b0;
        end
        else if (ce)
        begin
            storage_flag_q <= storage_flag_d;
        end
    end

    // timers and registered outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tick_cnt_q <= '0;
            wd_ms_q    <= '0;
            expire_q   <= 1'b0;
            rdata_q    <= 8'h00;
            target_q   <= secondary_linear_regulator_mv(VCODE_RESET, OFFSET_SEL_RESET);
        end
        else if (ce)
        begin
            tick_cnt_q <= tick_cnt_d;
            wd_ms_q    <= wd_ms_d;
            expire_q   <= wd_hit;
            rdata_q    <= rdata_d;
            target_q   <= secondary_linear_regulator_mv(vcode_q, offset_sel_q);
        end
    end

    assign reg_rdata            = rdata_q;
    assign wd_expire            = expire_q;
    assign secondary_linear_regulator_mode3_target_mv = target_q;
endmodule
`default_nettype wire
